//--- verilog/sgp_regs.svh
// Contract
// (R1) Device refuses writes to protected groups
// (R2) Cleared protection re-enables program and erase
// (R3) Permanent protect uses bus cycles under high voltage
// (R4) Host protects all groups before unprotecting
// (R5) All groups ship unprotected
// (R6) Groups decode from address bits A18..A12
// (R7) High voltage on reset pin lifts protection
// (R8) Removing high voltage restores prior protection
// (R9) Write-protect low keeps two boot sectors locked
// (R10) 256-byte secured region, lock bit on data_line_seven
// (R11) Indicator bit fixed: 1 factory, 0 customer
// (R12) Factory-locked region rejects every change
// (R13) Enter sequence overlays secured region on boot
// (R14) Overlay lasts until exit, reset or power
// (R15) Serial number at fixed low or top words
// (R16) Region programmed once; no unlock-bypass there
// (R17) Lock: enter, then protect at group 1Ah
// (R18) Host exits region before using main array
// (R19) Locked region can never be unprotected
// (R20) Verify read returns one protected, 00h not
// (R21) Top-boot indicator reads 8Eh or 0Eh
// (R22) Overlay at FFF00h-FFFFFh or lowest 256 bytes
// (R23) Refused program leaves array unchanged, readable
`ifndef SGP_REGS_SVH
`define SGP_REGS_SVH

// ****************************************
// Clock and bus timing
// ****************************************
`define SGP_CLK_NS 4
`define SGP_T_WP_NS 35
`define SGP_T_WPH_NS 20
`define SGP_T_ACC_NS 70
`define SGP_T_VID_NS 4000
`define SGP_T_PPULSE_NS 150000
`define SGP_T_UPULSE_NS 15000000
`define SGP_WP_CYC ((`SGP_T_WP_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_WPH_CYC ((`SGP_T_WPH_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_SYNC_CYC 4
`define SGP_ACC_CYC ((`SGP_T_ACC_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS + `SGP_SYNC_CYC)
`define SGP_VID_CYC ((`SGP_T_VID_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_PPULSE_CYC ((`SGP_T_PPULSE_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)
`define SGP_UPULSE_CYC ((`SGP_T_UPULSE_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)

// ****************************************
// Command addresses and codes (word mode)
// ****************************************
`define SGP_A_UNLOCK1 19'h00555
`define SGP_A_UNLOCK2 19'h002AA
`define SGP_A_ZERO 19'h00000
`define SGP_D_UNLOCK1 16'h00AA
`define SGP_D_UNLOCK2 16'h0055
`define SGP_D_SSR_ENTER 16'h0088
`define SGP_D_AUTOSEL 16'h0090
`define SGP_D_EXIT 16'h0000
`define SGP_D_RESET 16'h00F0
`define SGP_D_PROT 16'h0060
`define SGP_D_VERIFY 16'h0040
`define SGP_A_PROT_LOW 19'h00002
`define SGP_A_UNPROT_LOW 19'h00042
`define SGP_A_SSR_GROUP 19'h0001A
`define SGP_A_VERIFY_LOW 19'h00002
`define SGP_A_IND_LOW 19'h00003
`define SGP_A_SN_BOT 19'h00000
`define SGP_A_SN_TOP 19'h7FFF8
`define SGP_IND_BIT 7
`define SGP_LAST_GROUP 4'h8

`endif

//--- verilog/sgp_pkg.sv
package sgp_pkg;

    // ****************************************
    // Host operations
    // ****************************************
    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_WRITE = 4'h1,
        OP_PROTECT = 4'h2,
        OP_UNPROT_ALL = 4'h3,
        OP_VERIFY = 4'h4,
        OP_TEMP_ON = 4'h5,
        OP_TEMP_OFF = 4'h6,
        OP_SSR_ENTER = 4'h7,
        OP_SSR_EXIT = 4'h8,
        OP_SSR_LOCK = 4'h9,
        OP_INDICATOR = 4'hA
    } sgp_op_type;

    typedef enum logic [2:0] {
        K_END = 3'h0,
        K_WR = 3'h1,
        K_RD = 3'h2,
        K_PPULSE = 3'h3,
        K_UPULSE = 3'h4
    } sgp_kind_type;

    typedef enum logic [1:0] {
        CHK_NONE = 2'h0,
        CHK_ONE = 2'h1,
        CHK_ZERO = 2'h2
    } sgp_chk_type;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        sgp_op_type op;
        logic [3:0] grp;
        logic [18:0] addr;
        logic [15:0] data;
    } sgp_req_type;

    typedef struct packed {
        logic [15:0] rdata;
        logic prot;
        logic ind;
        logic fail;
    } sgp_rsp_type;

    typedef struct packed {
        sgp_kind_type kind;
        sgp_chk_type chk;
        logic [18:0] addr;
        logic [15:0] data;
    } sgp_step_type;

    typedef struct packed {
        logic [18:0] addr;
        logic [15:0] dq;
        logic dq_oe;
        logic ce_b;
        logic oe_b;
        logic we_b;
    } sgp_pins_type;

endpackage : sgp_pkg

//--- verilog/sgp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sgp_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Pin side and result
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
    logic [W-1:0] q_next;

    // A change counts only once stages two and three agree
    always_comb begin
        q_next = q_reg;
        if (s2_reg == s3_reg) begin
            q_next = s3_reg;
        end
    end

    // Three-stage chain
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : sgp_sync
`default_nettype wire

//--- verilog/sgp_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "sgp_regs.svh"
module sgp_host #(
    parameter bit BOOT_TOP = 1'b1,
    parameter logic [23:0] PPULSE_CYC = 24'(`SGP_PPULSE_CYC),
    parameter logic [23:0] UPULSE_CYC = 24'(`SGP_UPULSE_CYC)
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // User command port
    input wire logic CMD_VALID_I,
    input wire sgp_pkg::sgp_req_type CMD_I,
    output logic CMD_READY_O,
    output logic DONE_O,
    output sgp_pkg::sgp_rsp_type RSP_O,
    output logic TEMP_MODE_O,
    output logic OVERLAY_O,
    input wire logic WP_B_I,
    // Flash pins
    output sgp_pkg::sgp_pins_type FL_PINS_O,
    input wire logic [15:0] FL_DQ_I,
    output logic FL_RESET_B_O,
    output logic FL_HIGH_VOLTAGE_LEVEL_O,
    output logic FL_WP_B_O
);
    import sgp_pkg::*;

    // ****************************************
    // State, Gray codes in declaration order
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HV_UP = 3'b001,
        S_STEP = 3'b011,
        S_STROBE = 3'b010,
        S_RECOVER = 3'b110,
        S_WAIT = 3'b111,
        S_HV_DN = 3'b101
    } sgp_state_type;

    sgp_state_type state_reg, state_next;
    sgp_req_type req_reg, req_next;
    sgp_rsp_type rsp_reg, rsp_next;
    sgp_pins_type pins_reg, pins_next;
    logic [3:0] step_reg, step_next;
    logic [3:0] grp_reg, grp_next;
    logic [23:0] timer_reg, timer_next;
    logic hv_reg, hv_next;
    logic temp_reg, temp_next;
    logic overlay_reg, overlay_next;
    logic done_reg, done_next;
    logic wp_reg, wp_next;
    logic [15:0] dq_sync;
    sgp_step_type cur;

    sgp_sync #(.W(16)) u_dq_sync (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .d_i(FL_DQ_I),
        .q_o(dq_sync)
    );

    // ****************************************
    // Group and step tables
    // ****************************************
    // First address bits A18..A12 of each protection group
    function automatic logic [6:0] group_bits(input logic [3:0] g);
        logic [6:0] b;
        b = 7'h00;
        if (BOOT_TOP) begin
            unique case (g)
                4'h0: b = 7'h00;
                4'h1: b = 7'h20;
                4'h2: b = 7'h40;
                4'h3: b = 7'h60;
                4'h4: b = 7'h70;
                4'h5: b = 7'h78;
                4'h6: b = 7'h7C;
                4'h7: b = 7'h7D;
                default: b = 7'h7E;
            endcase
        end else begin
            unique case (g)
                4'h0: b = 7'h00;
                4'h1: b = 7'h02;
                4'h2: b = 7'h03;
                4'h3: b = 7'h04;
                4'h4: b = 7'h08;
                4'h5: b = 7'h10;
                4'h6: b = 7'h20;
                4'h7: b = 7'h40;
                default: b = 7'h60;
            endcase
        end
        return b; // R6
    endfunction : group_bits

    function automatic sgp_step_type mk(input sgp_kind_type k, input logic [18:0] a, input logic [15:0] d,
                                        input sgp_chk_type c);
        return '{k, c, a, d};
    endfunction : mk

    // Bus step for op, step and group
    always_comb begin
        logic [18:0] ga;
        ga = {group_bits(grp_reg), 12'h000};
        cur = '0;
        unique case (req_reg.op)
            OP_READ: if (step_reg == 4'h0) cur = mk(K_RD, req_reg.addr, 16'h0000, CHK_NONE);
            OP_WRITE: if (step_reg == 4'h0) cur = mk(K_WR, req_reg.addr, req_reg.data, CHK_NONE);
            OP_PROTECT, OP_UNPROT_ALL: begin
                // Protect, pulse, verify R1 R23
                unique case (step_reg)
                    4'h0: cur = mk(K_WR, ga | `SGP_A_PROT_LOW, `SGP_D_PROT, CHK_NONE); // R3
                    4'h1: cur = mk(K_PPULSE, ga, 16'h0000, CHK_NONE);
                    4'h2: cur = mk(K_WR, ga | `SGP_A_PROT_LOW, `SGP_D_VERIFY, CHK_NONE);
                    4'h3: cur = mk(K_RD, ga | `SGP_A_PROT_LOW, 16'h0000, CHK_ONE); // R20
                    4'h4: if (req_reg.op == OP_UNPROT_ALL) cur = mk(K_WR, `SGP_A_UNPROT_LOW, `SGP_D_PROT, CHK_NONE);
                    4'h5: if (req_reg.op == OP_UNPROT_ALL) cur = mk(K_UPULSE, `SGP_A_ZERO, 16'h0000, CHK_NONE);
                    4'h6: if (req_reg.op == OP_UNPROT_ALL) cur = mk(K_WR, `SGP_A_UNPROT_LOW, `SGP_D_VERIFY, CHK_NONE);
                    4'h7: if (req_reg.op == OP_UNPROT_ALL) cur = mk(K_RD, `SGP_A_UNPROT_LOW, 16'h0000, CHK_ZERO); // R2 R5
                    default: cur = '0;
                endcase
            end
            OP_VERIFY, OP_INDICATOR: begin
                unique case (step_reg)
                    4'h0: cur = mk(K_WR, `SGP_A_UNLOCK1, `SGP_D_UNLOCK1, CHK_NONE);
                    4'h1: cur = mk(K_WR, `SGP_A_UNLOCK2, `SGP_D_UNLOCK2, CHK_NONE);
                    4'h2: cur = mk(K_WR, `SGP_A_UNLOCK1, `SGP_D_AUTOSEL, CHK_NONE);
                    4'h3: cur = (req_reg.op == OP_VERIFY) ? mk(K_RD, ga | `SGP_A_VERIFY_LOW, 16'h0000, CHK_NONE)
                                : mk(K_RD, `SGP_A_IND_LOW, 16'h0000, CHK_NONE); // R20 R21
                    4'h4: cur = mk(K_WR, `SGP_A_ZERO, `SGP_D_RESET, CHK_NONE);
                    default: cur = '0;
                endcase
            end
            OP_SSR_ENTER, OP_SSR_EXIT, OP_SSR_LOCK: begin
                // Lock: enter, protect, verify, exit R12 R16 R17 R18 R19
                unique case (step_reg)
                    4'h0, 4'h7: cur = mk(K_WR, `SGP_A_UNLOCK1, `SGP_D_UNLOCK1, CHK_NONE);
                    4'h1, 4'h8: cur = mk(K_WR, `SGP_A_UNLOCK2, `SGP_D_UNLOCK2, CHK_NONE);
                    4'h2: cur = mk(K_WR, `SGP_A_UNLOCK1,
                                   (req_reg.op == OP_SSR_EXIT) ? `SGP_D_AUTOSEL : `SGP_D_SSR_ENTER, CHK_NONE);
                    4'h3: if (req_reg.op == OP_SSR_EXIT) cur = mk(K_WR, `SGP_A_ZERO, `SGP_D_EXIT, CHK_NONE);
                          else if (req_reg.op == OP_SSR_LOCK) cur = mk(K_WR, `SGP_A_SSR_GROUP, `SGP_D_PROT, CHK_NONE);
                    4'h4: if (req_reg.op == OP_SSR_LOCK) cur = mk(K_PPULSE, `SGP_A_ZERO, 16'h0000, CHK_NONE);
                    4'h5: if (req_reg.op == OP_SSR_LOCK) cur = mk(K_WR, `SGP_A_SSR_GROUP, `SGP_D_VERIFY, CHK_NONE);
                    4'h6: if (req_reg.op == OP_SSR_LOCK) cur = mk(K_RD, `SGP_A_SSR_GROUP, 16'h0000, CHK_ONE); // R19
                    4'h9: cur = mk(K_WR, `SGP_A_UNLOCK1, `SGP_D_AUTOSEL, CHK_NONE);
                    4'hA: cur = mk(K_WR, `SGP_A_ZERO, `SGP_D_EXIT, CHK_NONE);
                    default: cur = '0;
                endcase
            end
            default: cur = '0;
        endcase
    end

    // ****************************************
    // Sequencer next state
    // ****************************************
    // Ops held under high voltage
    function automatic logic needs_hv(input sgp_op_type op);
        return (op == OP_PROTECT) || (op == OP_UNPROT_ALL) || (op == OP_SSR_LOCK); // R3
    endfunction : needs_hv

    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        rsp_next = rsp_reg;
        pins_next = pins_reg;
        step_next = step_reg;
        grp_next = grp_reg;
        timer_next = (timer_reg != '0) ? timer_reg - 24'h1 : timer_reg;
        hv_next = hv_reg;
        temp_next = temp_reg;
        overlay_next = overlay_reg;
        done_next = 1'b0;
        wp_next = WP_B_I; // R9
        unique case (state_reg)
            S_IDLE: begin
                if (CMD_VALID_I) begin
                    req_next = CMD_I;
                    step_next = 4'h0;
                    rsp_next.fail = 1'b0;
                    // Unprotect-all first protects every group R4
                    grp_next = (CMD_I.op == OP_UNPROT_ALL) ? 4'h0 : CMD_I.grp;
                    timer_next = 24'(`SGP_VID_CYC) - 24'h1;
                    if (CMD_I.op == OP_TEMP_ON || CMD_I.op == OP_TEMP_OFF) begin
                        temp_next = (CMD_I.op == OP_TEMP_ON); // R7 R8
                        hv_next = (CMD_I.op == OP_TEMP_ON);
                        state_next = S_HV_DN;
                    end else if (needs_hv(CMD_I.op)) begin
                        hv_next = 1'b1;
                        state_next = S_HV_UP;
                    end else begin
                        state_next = S_STEP;
                    end
                end
            end
            S_HV_UP: if (timer_reg == '0) state_next = S_STEP;
            S_STEP: begin
                pins_next.addr = cur.addr;
                pins_next.dq = cur.data;
                unique case (cur.kind)
                    K_WR: begin
                        pins_next.dq_oe = 1'b1;
                        pins_next.ce_b = 1'b0;
                        pins_next.we_b = 1'b0;
                        timer_next = 24'(`SGP_WP_CYC) - 24'h1;
                        state_next = S_STROBE;
                    end
                    K_RD: begin
                        pins_next.ce_b = 1'b0;
                        pins_next.oe_b = 1'b0;
                        timer_next = 24'(`SGP_ACC_CYC) - 24'h1;
                        state_next = S_STROBE;
                    end
                    K_PPULSE, K_UPULSE: begin
                        timer_next = ((cur.kind == K_PPULSE) ? PPULSE_CYC : UPULSE_CYC) - 24'h1;
                        state_next = S_WAIT;
                    end
                    K_END: begin
                        // Overlay follows the enter and exit sequences R13 R14 R15 R22
                        if (req_reg.op == OP_SSR_ENTER) overlay_next = 1'b1;
                        if (req_reg.op == OP_SSR_EXIT || req_reg.op == OP_SSR_LOCK) overlay_next = 1'b0;
                        // Drop high voltage unless temporary mode holds it R8
                        hv_next = temp_reg;
                        timer_next = 24'(`SGP_VID_CYC) - 24'h1;
                        state_next = S_HV_DN;
                    end
                    default: state_next = S_HV_DN;
                endcase
            end
            S_STROBE: begin
                if (timer_reg == '0) begin
                    if (cur.kind == K_RD) begin
                        rsp_next.rdata = dq_sync;
                        if (req_reg.op == OP_VERIFY) rsp_next.prot = dq_sync[0]; // R20
                        if (req_reg.op == OP_INDICATOR) rsp_next.ind = dq_sync[`SGP_IND_BIT]; // R10 R11
                        if ((cur.chk == CHK_ONE && !dq_sync[0]) || (cur.chk == CHK_ZERO && dq_sync[0])) begin
                            rsp_next.fail = 1'b1;
                        end
                    end
                    pins_next.dq_oe = 1'b0;
                    pins_next.ce_b = 1'b1;
                    pins_next.oe_b = 1'b1;
                    pins_next.we_b = 1'b1;
                    timer_next = 24'(`SGP_WPH_CYC) - 24'h1;
                    state_next = S_RECOVER;
                end
            end
            S_RECOVER, S_WAIT: begin
                if (timer_reg == '0) begin
                    // Protect every group before unprotecting R4
                    if (req_reg.op == OP_UNPROT_ALL && step_reg == 4'h3 && grp_reg != `SGP_LAST_GROUP) begin
                        grp_next = grp_reg + 4'h1;
                        step_next = 4'h0;
                    end else begin
                        step_next = step_reg + 4'h1;
                    end
                    state_next = S_STEP;
                end
            end
            S_HV_DN: begin
                if (timer_reg == '0) begin
                    done_next = 1'b1;
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg <= S_IDLE;
            req_reg <= '0;
            rsp_reg <= '0;
            pins_reg <= '{19'h00000, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b1};
            step_reg <= 4'h0;
            grp_reg <= 4'h0;
            timer_reg <= '0;
            hv_reg <= 1'b0;
            temp_reg <= 1'b0;
            overlay_reg <= 1'b0;
            done_reg <= 1'b0;
            wp_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            rsp_reg <= rsp_next;
            pins_reg <= pins_next;
            step_reg <= step_next;
            grp_reg <= grp_next;
            timer_reg <= timer_next;
            hv_reg <= hv_next;
            temp_reg <= temp_next;
            overlay_reg <= overlay_next;
            done_reg <= done_next;
            wp_reg <= wp_next;
        end
    end

    // Outputs
    assign CMD_READY_O = (state_reg == S_IDLE);
    assign DONE_O = done_reg;
    assign RSP_O = rsp_reg;
    assign TEMP_MODE_O = temp_reg;
    assign OVERLAY_O = overlay_reg;
    assign FL_PINS_O = pins_reg;
    assign FL_RESET_B_O = 1'b1; // Never pulse reset; overlay stays under host control
    assign FL_HIGH_VOLTAGE_LEVEL_O = hv_reg;
    assign FL_WP_B_O = wp_reg;
endmodule : sgp_host
`default_nettype wire

//--- verif/sgp_host_chk.sv
`timescale 1ns/1ns
`default_nettype none
module sgp_host_chk (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Watched ports
    input wire logic CMD_READY_O,
    input wire logic DONE_O,
    input wire logic TEMP_MODE_O,
    input wire logic WP_B_I,
    input wire sgp_pkg::sgp_pins_type FL_PINS_O,
    input wire logic FL_HIGH_VOLTAGE_LEVEL_O,
    input wire logic FL_WP_B_O
);
    import sgp_pkg::*;
    // ********
    // Bus cycle shape
    // ********
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    property p_we_ce; !FL_PINS_O.we_b |-> !FL_PINS_O.ce_b && FL_PINS_O.oe_b && FL_PINS_O.dq_oe; endproperty
    a_we_ce: assert property (p_we_ce) else $error("write strobe without select");
    property p_we_hold;
        $fell(FL_PINS_O.we_b) |=> (!FL_PINS_O.we_b && $stable(FL_PINS_O.addr)
            && $stable(FL_PINS_O.dq))[*8] ##1 FL_PINS_O.we_b;
    endproperty
    a_we_hold: assert property (p_we_hold) else $error("write pulse not 9 cycles");
    property p_rd_hold; $fell(FL_PINS_O.oe_b) |=> (!FL_PINS_O.oe_b && $stable(FL_PINS_O.addr))[*8]; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read cut short");
    property p_no_fight; !FL_PINS_O.oe_b |-> !FL_PINS_O.dq_oe; endproperty
    a_no_fight: assert property (p_no_fight) else $error("data bus contention");
    // ********
    // High voltage and mode levels
    // ********
    property p_hv_prot; !FL_PINS_O.we_b && FL_PINS_O.dq == 16'h0060 |-> FL_HIGH_VOLTAGE_LEVEL_O; endproperty
    a_hv_prot: assert property (p_hv_prot) else $error("protect write without high voltage");
    property p_temp_hv; TEMP_MODE_O && CMD_READY_O |-> FL_HIGH_VOLTAGE_LEVEL_O; endproperty
    a_temp_hv: assert property (p_temp_hv) else $error("temporary mode without high voltage");
    property p_done_ready; DONE_O |=> CMD_READY_O; endproperty
    a_done_ready: assert property (p_done_ready) else $error("not ready after done");
    property p_wp; ##1 FL_WP_B_O == $past(WP_B_I); endproperty
    a_wp: assert property (p_wp) else $error("write protect not passed on");
    c_temp: cover property (DONE_O && TEMP_MODE_O);
    c_hv_write: cover property ($fell(FL_PINS_O.we_b) && FL_HIGH_VOLTAGE_LEVEL_O);
    c_read: cover property ($fell(FL_PINS_O.oe_b));
endmodule : sgp_host_chk
bind sgp_host sgp_host_chk i_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CMD_READY_O(CMD_READY_O),
    .DONE_O(DONE_O), .TEMP_MODE_O(TEMP_MODE_O), .WP_B_I(WP_B_I), .FL_PINS_O(FL_PINS_O),
    .FL_HIGH_VOLTAGE_LEVEL_O(FL_HIGH_VOLTAGE_LEVEL_O), .FL_WP_B_O(FL_WP_B_O));
`default_nettype wire

//--- verif/sgp_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module sgp_flash_model #(
    parameter bit FACTORY = 1'b0,
    parameter logic [15:0] SN = 16'h5A3C // Arbitrary serial word
) (
    // Flash pins
    input wire sgp_pkg::sgp_pins_type pins_i,
    input wire logic hv_i,
    input wire logic wp_b_i,
    output logic [15:0] dq_o
);
    import sgp_pkg::*;
    // ********
    // Array and protection state
    // ********
    logic [8:0] prot = '0;
    logic [15:0] mem [logic [18:0]];
    logic [15:0] ssr [logic [18:0]];
    logic [1:0] ulk = '0;
    logic idm = 0, ovl = 0, ver = 0, pgm = 0, ssr_lk = FACTORY;
    logic [15:0] rdv = '0;
    logic [18:0] a;
    logic [15:0] d;
    function automatic int grp(input logic [18:0] x);
        logic [6:0] h;
        h = x[18:12];
        return h >= 7'h7E ? 8 : h >= 7'h7D ? 7 : h >= 7'h7C ? 6 : h >= 7'h78 ? 5 : h >= 7'h70 ? 4
            : h >= 7'h60 ? 3 : h >= 7'h40 ? 2 : h >= 7'h20 ? 1 : 0;
    endfunction : grp
    function automatic logic [15:0] rd(input logic [18:0] x);
        if (ver) return {15'h0, (ovl && x[7:0] == 8'h1A) ? ssr_lk : prot[grp(x)]};
        if (idm) return x[1:0] == 2'h2 ? {15'h0, prot[grp(x)]} : {8'h0, FACTORY, 7'h0E};
        if (ovl && x >= 19'h7FF80) return x >= 19'h7FFF8 ? SN : ssr.exists(x) ? ssr[x] : 16'hFFFF;
        return mem.exists(x) ? mem[x] : 16'hFFFF;
    endfunction : rd
    // Write at strobe start
    always @(negedge pins_i.we_b) if (!pins_i.ce_b) begin
        a = pins_i.addr;
        d = pins_i.dq;
        ver = 1'b0;
        if (pgm) begin
            pgm = 1'b0;
            if (ovl && a >= 19'h7FF80) begin
                if (!ssr_lk) ssr[a] = d;
            end else if (!(prot[grp(a)] && (!hv_i || (!wp_b_i && grp(a) >= 7)))) begin
                mem[a] = d;
            end
        end else if (d == 16'h00F0) begin
            idm = 1'b0;
            ulk = 2'h0;
        end else if (ulk == 2'h0 && a == 19'h00555 && d == 16'h00AA) begin
            ulk = 2'h1;
        end else if (ulk == 2'h1 && a == 19'h002AA && d == 16'h0055) begin
            ulk = 2'h2;
        end else if (ulk == 2'h2) begin
            ulk = 2'h0;
            idm = d == 16'h0090;
            ovl = ovl || d == 16'h0088;
            pgm = d == 16'h00A0;
        end else if (d == 16'h0060 && hv_i) begin
            if (ovl && a[7:0] == 8'h1A) ssr_lk = 1'b1;
            else if (a[6]) prot = '0;
            else prot[grp(a)] = 1'b1;
        end else if (d == 16'h0040) begin
            ver = 1'b1;
        end else if (idm && d == 16'h0000) begin
            idm = 1'b0;
            ovl = 1'b0;
        end
    end
    // Undriven bus shows the inverse
    always @(negedge pins_i.oe_b) if (!pins_i.ce_b) rdv = rd(pins_i.addr);
    assign dq_o = (!pins_i.ce_b && !pins_i.oe_b) ? rdv : ~rdv;
endmodule : sgp_flash_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sgp_pkg::*;
    // ********
    // Clock, reset and wiring
    // ********
    logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, wp_b = 1'b1;
    logic ready, done, temp, ovl, fl_rst_b, hv, fl_wp_b;
    logic [15:0] fl_dq, d0, d1;
    logic [17:0] e;
    logic [17:0] exp_q[$];
    sgp_req_type cmd = '0;
    sgp_rsp_type rsp;
    sgp_pins_type pins;
    int fails = 0, n_checks = 0, seed = 32'h1218DFD9;
    always #2 clk = ~clk;
    sgp_host #(.PPULSE_CYC(24'h8), .UPULSE_CYC(24'h8)) i_dut (.CLK_I(clk), .RST_B_I(rst_b),
        .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .CMD_READY_O(ready), .DONE_O(done), .RSP_O(rsp),
        .TEMP_MODE_O(temp), .OVERLAY_O(ovl), .WP_B_I(wp_b), .FL_PINS_O(pins), .FL_DQ_I(fl_dq),
        .FL_RESET_B_O(fl_rst_b), .FL_HIGH_VOLTAGE_LEVEL_O(hv), .FL_WP_B_O(fl_wp_b));
    sgp_flash_model i_flash (.pins_i(pins), .hv_i(hv), .wp_b_i(fl_wp_b), .dq_o(fl_dq));
    // ********
    // Checking and ending
    // ********
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // Oldest note against each finished op
    always @(posedge clk) if (done === 1'b1 && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check({15'h0, rsp.fail}, 16'h0);
        case (e[17:16])
            2'h1: check(rsp.rdata, e[15:0]);
            2'h2: check({15'h0, rsp.prot}, e[15:0]);
            2'h3: check({15'h0, rsp.ind}, e[15:0]);
            default: ;
        endcase
    end
    // One op, bounded waits
    task automatic op(input sgp_op_type o, input logic [3:0] g = 4'h0, input logic [18:0] a = '0,
                      input logic [15:0] d = '0, input logic [1:0] sel = 2'h0, input logic [15:0] v = 16'h0);
        int n;
        exp_q.push_back({sel, v});
        @(negedge clk);
        cmd = '{o, g, a, d};
        cmd_valid = 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 99);
        @(negedge clk);
        cmd_valid = 1'b0;
        do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 60000);
        if (n >= 60000) begin
            fails++;
            print_verdict();
        end
    endtask : op
    task automatic prog(input logic [18:0] a, input logic [15:0] d);
        op(OP_WRITE, 4'h0, 19'h00555, 16'h00AA);
        op(OP_WRITE, 4'h0, 19'h002AA, 16'h0055);
        op(OP_WRITE, 4'h0, 19'h00555, 16'h00A0);
        op(OP_WRITE, 4'h0, a, d);
    endtask : prog
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        for (int g = 0; g < 9; g++) op(OP_VERIFY, 4'(g), '0, '0, 2'h2);
        op(OP_PROTECT, 4'h2);
        op(OP_VERIFY, 4'h2, '0, '0, 2'h2, 16'h1);
        op(OP_VERIFY, 4'h3, '0, '0, 2'h2);
        d0 = 16'($random(seed));
        d1 = 16'($random(seed));
        prog(19'h40010, d0);
        op(OP_READ, 4'h0, 19'h40010, '0, 2'h1, 16'hFFFF);
        op(OP_TEMP_ON);
        check({15'h0, temp}, 16'h1);
        prog(19'h40010, d0);
        op(OP_READ, 4'h0, 19'h40010, '0, 2'h1, d0);
        op(OP_TEMP_OFF);
        op(OP_VERIFY, 4'h2, '0, '0, 2'h2, 16'h1);
        @(negedge clk) wp_b = 1'b0;
        op(OP_PROTECT, 4'h8);
        op(OP_TEMP_ON);
        prog(19'h7E000, d1);
        op(OP_READ, 4'h0, 19'h7E000, '0, 2'h1, 16'hFFFF);
        op(OP_TEMP_OFF);
        @(negedge clk) wp_b = 1'b1;
        op(OP_UNPROT_ALL);
        op(OP_VERIFY, 4'h2, '0, '0, 2'h2);
        op(OP_INDICATOR, 4'h0, '0, '0, 2'h3);
        op(OP_SSR_ENTER);
        check({15'h0, ovl}, 16'h1);
        op(OP_READ, 4'h0, 19'h7FFF8, '0, 2'h1, 16'h5A3C);
        op(OP_SSR_LOCK);
        op(OP_SSR_ENTER);
        prog(19'h7FF80, d1);
        op(OP_READ, 4'h0, 19'h7FF80, '0, 2'h1, 16'hFFFF);
        op(OP_SSR_EXIT);
        check({15'h0, ovl}, 16'h0);
        op(OP_READ, 4'h0, 19'h7FFF8, '0, 2'h1, 16'hFFFF);
        check({15'h0, fl_rst_b}, 16'h1);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
